//--- hdl/fsrt_defines.svh
/*
 * register indices, field positions, reset values and timing counts of the
 * flying start / ride-through sequencer.
 * assumes a 250 MHz clock and a 1 ms supervisory tick.
 */
`ifndef FSRT_DEFINES_SVH
`define FSRT_DEFINES_SVH

// word indices; byte address is four times the index
`define FSRT_IDX_CTRL 3'h0
`define FSRT_IDX_VRAMP 3'h1
`define FSRT_IDX_SRCH 3'h2
`define FSRT_IDX_TIME 3'h3
`define FSRT_IDX_LVL1 3'h4
`define FSRT_IDX_LVL2 3'h5
`define FSRT_IDX_MAXS 3'h6
`define FSRT_IDX_STAT 3'h7
`define FSRT_NCFG 7

// control register fields
`define FSRT_SEL_LSB 0
`define FSRT_CTYPE_LSB 4
`define FSRT_DIFN_LSB 8
`define FSRT_CTRL_MASK 32'h0000FF77
`define FSRT_FULL_MASK 32'hFFFFFFFF
`define FSRT_UVF_BIT 16
`define FSRT_RSF_BIT 17

// reset values
`define FSRT_CTRL_RST 32'h00000000
`define FSRT_VRAMP_RST 32'h000007D0
`define FSRT_SRCH_RST 32'h0064003C
`define FSRT_TIME_RST 32'h00550046
`define FSRT_LVL1_RST 32'h00F500FC
`define FSRT_LVL2_RST 32'h00C8010B
`define FSRT_MAXS_RST 32'h00100708

// selection and function codes
`define FSRT_SEL_FS 3'h1
`define FSRT_SEL_FSRT 3'h2
`define FSRT_SEL_RT 3'h3
`define FSRT_CT_SLESS 3'h3
`define FSRT_CT_ENC 3'h4
`define FSRT_DI_SCALAR 8'h18
`define FSRT_DI_VECTOR 8'h0F

// amplitude and sweep scaling
`define FSRT_AMP_FULL 16'hFFFF
`define FSRT_SWEEP_SHIFT 8
`define FSRT_AMP_SHIFT 6
`define FSRT_UV_HYST 16'h000A

// timing
`define FSRT_CLK_NS 4
`define FSRT_TICK_NS 1000000
`define FSRT_TICK_CYCLES (`FSRT_TICK_NS / `FSRT_CLK_NS)
`define FSRT_RT_MAX_MS 2000
`define FSRT_RT_MAX_TICKS (`FSRT_RT_MAX_MS * 1000000 / `FSRT_TICK_NS)
`define FSRT_RSF_MS 500
`define FSRT_RSF_TICKS (`FSRT_RSF_MS * 1000000 / `FSRT_TICK_NS)

`endif

//--- hdl/fsrt_pkg.sv
/*
 * types of the flying start / ride-through sequencer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package fsrt_pkg;
  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_MAGNET = 9'h002,
    ST_SRAMP  = 9'h004,
    ST_RUN    = 9'h008,
    ST_BLOCK  = 9'h010,
    ST_SPOS   = 9'h020,
    ST_SNEG   = 9'h040,
    ST_HOLD   = 9'h080,
    ST_TRIP   = 9'h100
  } state_type;
endpackage

//--- hdl/flying_start_ride_through_seq.sv
/*
 * flying start / ride-through sequencer for a motor inverter, with a
 * classic wishbone register slave.
 * assumes link voltage, speeds and enables come from logic on clk_in;
 * only the digital disable input is asynchronous.
 */
`include "fsrt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module flying_start_ride_through_seq #(
  parameter int unsigned TICK_CYCLES = `FSRT_TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  // wishbone slave
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [7:0]         wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output var  logic [31:0]        wb_dat_out,
  output var  logic               wb_ack_out,
  // commands
  input  wire logic               gen_enable_in,
  input  wire logic               run_in,
  input  wire logic               fs_disable_pin_in,
  // measurements
  input  wire logic [15:0]        link_voltage_in,
  input  wire logic signed [15:0] speed_reference_in,
  input  wire logic signed [15:0] motor_speed_in,
  input  wire logic               magnetize_done_in,
  // drive outputs
  output logic                    pulse_enable_out,
  output logic signed [15:0]      freq_ref_out,
  output logic [15:0]             volt_ref_out,
  output logic [15:0]             current_ref_out,
  output logic                    magnetize_out,
  output logic                    vector_ctrl_out,
  output logic                    link_reg_active_out,
  output logic [15:0]             link_reg_target_out,
  output logic                    reaccel_out,
  output logic signed [15:0]      ramp_start_out,
  output logic                    phase_loss_ignore_out,
  output logic                    undervoltage_fault_out,
  output logic                    ride_setting_fault_out
);
  ////////////////////////////////////////////////////////////////////////////
  // register file
  localparam logic [31:0] CFG_RST [`FSRT_NCFG] = '{`FSRT_CTRL_RST,
    `FSRT_VRAMP_RST, `FSRT_SRCH_RST, `FSRT_TIME_RST, `FSRT_LVL1_RST,
    `FSRT_LVL2_RST, `FSRT_MAXS_RST};
  localparam logic [31:0] CFG_MSK [`FSRT_NCFG] = '{`FSRT_CTRL_MASK,
    `FSRT_FULL_MASK, `FSRT_FULL_MASK, `FSRT_FULL_MASK, `FSRT_FULL_MASK,
    `FSRT_FULL_MASK, `FSRT_FULL_MASK};

  logic [31:0] cfg_q [`FSRT_NCFG];
  logic        ack_q;
  logic [31:0] rdat_q;
  wire         bus_req = wb_cyc_in & wb_stb_in & ~ack_q;
  wire         bus_wr = bus_req & wb_we_in;
  wire  [2:0]  bus_idx = wb_adr_in[4:2];
  wire         bus_hit = (wb_adr_in[7:5] == 3'h0);
  wire  [31:0] byte_msk = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                           {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  genvar gi;
  generate
    for (gi = 0; gi < `FSRT_NCFG; gi++) begin : g_cfg
      always_ff @(posedge clk_in) begin
        if (sys_rst_in)
          cfg_q[gi] <= CFG_RST[gi];
        else if (bus_wr && bus_hit && bus_idx == 3'(gi))
          cfg_q[gi] <= ((cfg_q[gi] & ~byte_msk) | (wb_dat_in & byte_msk)) & CFG_MSK[gi];
      end
    end
  endgenerate

  wire [2:0]  sel = cfg_q[`FSRT_IDX_CTRL][`FSRT_SEL_LSB +: 3];
  wire [2:0]  ctype = cfg_q[`FSRT_IDX_CTRL][`FSRT_CTYPE_LSB +: 3];
  wire [7:0]  di_func = cfg_q[`FSRT_IDX_CTRL][`FSRT_DIFN_LSB +: 8];
  wire [15:0] vramp = cfg_q[`FSRT_IDX_VRAMP][15:0];
  wire [15:0] sfr = cfg_q[`FSRT_IDX_SRCH][15:0];
  wire [15:0] trc = cfg_q[`FSRT_IDX_SRCH][31:16];
  wire [15:0] crmp = cfg_q[`FSRT_IDX_TIME][15:0];
  wire [15:0] filt = cfg_q[`FSRT_IDX_TIME][31:16];
  wire [15:0] loss_lvl = cfg_q[`FSRT_IDX_LVL1][15:0];
  wire [15:0] hold_lvl = cfg_q[`FSRT_IDX_LVL1][31:16];
  wire [15:0] ret_lvl = cfg_q[`FSRT_IDX_LVL2][15:0];
  wire [15:0] uv_lvl = cfg_q[`FSRT_IDX_LVL2][31:16];
  wire [15:0] max_spd = cfg_q[`FSRT_IDX_MAXS][15:0];
  wire [15:0] win = cfg_q[`FSRT_IDX_MAXS][31:16];

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning and decode
  logic [2:0] dis_sync_q;
  logic       dis_lvl_q;
  logic       en_q;
  logic       gen_q;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dis_sync_q <= 3'h0;
      dis_lvl_q  <= 1'b0;
      en_q       <= 1'b0;
      gen_q      <= 1'b0;
    end else begin
      dis_sync_q <= {dis_sync_q[1:0], fs_disable_pin_in};
      if (dis_sync_q[2] == dis_sync_q[1])
        dis_lvl_q <= dis_sync_q[1];
      en_q  <= gen_enable_in & run_in;
      gen_q <= gen_enable_in;
    end
  end

  wire en = gen_enable_in & run_in;
  wire start = en & ~en_q;
  wire launch_gen = gen_enable_in & ~gen_q;
  wire scalar = (ctype < `FSRT_CT_SLESS);
  wire sless = (ctype == `FSRT_CT_SLESS);
  wire fs_sel = (sel == `FSRT_SEL_FS) | (sel == `FSRT_SEL_FSRT);
  wire rt_sel = (sel == `FSRT_SEL_FSRT) | (sel == `FSRT_SEL_RT);
  wire di_dis = dis_lvl_q & ((scalar & (di_func == `FSRT_DI_SCALAR))
              | (~scalar & (di_func == `FSRT_DI_VECTOR)));
  wire fs_go = fs_sel & ~di_dis;
  wire below_uv = link_voltage_in < uv_lvl;
  wire uv_back = link_voltage_in >= uv_lvl + `FSRT_UV_HYST;
  // threshold already in link terms, so loss/1.35 on supply needs no divide
  wire below_loss = link_voltage_in < loss_lvl;
  wire at_ret = link_voltage_in >= ret_lvl;
  wire stuck = (link_voltage_in > hold_lvl) & ~at_ret;

  ////////////////////////////////////////////////////////////////////////////
  // tick and counters
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [15:0] rt_cnt_q;
  logic [15:0] rsf_cnt_q;
  logic [15:0] fnd_cnt_q;
  fsrt_pkg::state_type st_q;
  fsrt_pkg::state_type st_d;
  logic signed [15:0] freq_q;
  logic [15:0] amp_q;
  wire         volt_full = amp_q == `FSRT_AMP_FULL;

  assign tick = (tick_cnt_q == TICK_CYCLES - 1);
  wire signed [16:0] spd_err = 17'(freq_q) - 17'(motor_speed_in);
  wire [16:0] spd_abs = spd_err[16] ? 17'(-spd_err) : 17'(spd_err);
  wire searching = (st_q == fsrt_pkg::ST_SPOS) | (st_q == fsrt_pkg::ST_SNEG);
  wire match = spd_abs <= {1'b0, win};
  wire found = searching & match & (fnd_cnt_q >= filt);
  wire rt_timeout = rt_cnt_q > 16'(`FSRT_RT_MAX_TICKS);
  wire [31:0] step_prod = sfr * trc;
  wire [15:0] step_raw = step_prod[`FSRT_SWEEP_SHIFT +: 16];
  wire [15:0] step = (step_raw == 16'h0000) ? 16'h0001 : step_raw;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tick_cnt_q <= 32'h0;
      rt_cnt_q   <= 16'h0;
      rsf_cnt_q  <= 16'h0;
      fnd_cnt_q  <= 16'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (st_q != fsrt_pkg::ST_BLOCK)
        rt_cnt_q <= 16'h0;
      else if (tick && !rt_timeout)
        rt_cnt_q <= rt_cnt_q + 16'h1;
      if (st_q != fsrt_pkg::ST_HOLD || !stuck)
        rsf_cnt_q <= 16'h0;
      else if (tick && rsf_cnt_q != 16'hFFFF)
        rsf_cnt_q <= rsf_cnt_q + 16'h1;
      if (!searching || !match)
        fnd_cnt_q <= 16'h0;
      else if (tick && fnd_cnt_q != 16'hFFFF)
        fnd_cnt_q <= fnd_cnt_q + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic uvf_q;
  logic rsf_q;
  always_comb begin
    st_d = st_q;
    case (st_q)
      fsrt_pkg::ST_IDLE: begin
        if (start && !uvf_q) begin
          if (scalar)
            st_d = fs_go ? fsrt_pkg::ST_SRAMP : fsrt_pkg::ST_RUN;
          else if (sless && fs_go && launch_gen)
            st_d = fsrt_pkg::ST_SPOS;
          else
            st_d = fsrt_pkg::ST_MAGNET;
        end
      end
      fsrt_pkg::ST_MAGNET: begin
        if (!en)
          st_d = fsrt_pkg::ST_IDLE;
        else if (magnetize_done_in)
          st_d = (sless && fs_go) ? fsrt_pkg::ST_SPOS : fsrt_pkg::ST_RUN;
      end
      fsrt_pkg::ST_SRAMP, fsrt_pkg::ST_RUN: begin
        if (!en)
          st_d = fsrt_pkg::ST_IDLE;
        else if (scalar && below_uv)
          st_d = rt_sel ? fsrt_pkg::ST_BLOCK : fsrt_pkg::ST_TRIP;
        else if (!scalar && rt_sel && below_loss && st_q == fsrt_pkg::ST_RUN)
          st_d = fsrt_pkg::ST_HOLD;
        else if (!scalar && below_uv)
          st_d = fsrt_pkg::ST_TRIP;
        else if (st_q == fsrt_pkg::ST_SRAMP && volt_full)
          st_d = fsrt_pkg::ST_RUN;
      end
      fsrt_pkg::ST_BLOCK: begin
        if (rt_timeout)
          st_d = fsrt_pkg::ST_TRIP;
        else if (uv_back)
          st_d = en ? fsrt_pkg::ST_SRAMP : fsrt_pkg::ST_IDLE;
      end
      fsrt_pkg::ST_SPOS: begin
        if (!en)
          st_d = fsrt_pkg::ST_IDLE;
        else if (found)
          st_d = fsrt_pkg::ST_RUN;
        else if (freq_q <= 16'sh0000)
          st_d = fsrt_pkg::ST_SNEG;
      end
      fsrt_pkg::ST_SNEG: begin
        if (!en)
          st_d = fsrt_pkg::ST_IDLE;
        else if (found || freq_q >= 16'sh0000)
          st_d = fsrt_pkg::ST_RUN;
      end
      fsrt_pkg::ST_HOLD: begin
        if (below_uv)
          st_d = fsrt_pkg::ST_TRIP;
        else if (!en)
          st_d = fsrt_pkg::ST_IDLE;
        else if (at_ret)
          st_d = fsrt_pkg::ST_RUN;
      end
      fsrt_pkg::ST_TRIP: begin
        if (!uvf_q && !en)
          st_d = fsrt_pkg::ST_IDLE;
      end
      default: st_d = fsrt_pkg::ST_IDLE;
    endcase
  end

  wire enter = st_d != st_q;
  wire uv_set = enter & (st_d == fsrt_pkg::ST_TRIP);
  wire rsf_set = rsf_cnt_q >= 16'(`FSRT_RSF_TICKS);
  wire stat_wr = bus_wr & bus_hit & (bus_idx == `FSRT_IDX_STAT);
  wire uvf_clr = stat_wr & wb_sel_in[2] & wb_dat_in[`FSRT_UVF_BIT];
  wire rsf_clr = stat_wr & wb_sel_in[2] & wb_dat_in[`FSRT_RSF_BIT];
  wire to_run = enter & (st_d == fsrt_pkg::ST_RUN);
  wire reacc_set = to_run & ((st_q == fsrt_pkg::ST_HOLD)
                 | ((st_q == fsrt_pkg::ST_MAGNET) & ~sless));

  ////////////////////////////////////////////////////////////////////////////
  // amplitude ramp: voltage in scalar, search current in sensorless
  logic [31:0] acc_q;
  wire         ramping = (st_q == fsrt_pkg::ST_SRAMP) | searching;
  wire  [15:0] ramp_len = scalar ? vramp : crmp;
  wire  [31:0] acc_in = tick ? acc_q + 32'(`FSRT_AMP_FULL) : acc_q;
  wire         amp_full = volt_full;
  // coarse steps of 64 keep the divider out; a ramp needs at least 1024 clocks
  wire  [31:0] amp_chunk = {16'h0000, ramp_len} << `FSRT_AMP_SHIFT;
  wire  [16:0] amp_sum = {1'b0, amp_q} + (17'h00001 << `FSRT_AMP_SHIFT);
  wire         amp_step = (acc_in >= amp_chunk) & ~amp_full;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !ramping || enter) begin
      amp_q <= (st_d == fsrt_pkg::ST_RUN) ? `FSRT_AMP_FULL : 16'h0000;
      acc_q <= 32'h0;
    end else if (ramp_len == 16'h0000) begin
      amp_q <= `FSRT_AMP_FULL;
      acc_q <= 32'h0;
    end else begin
      amp_q <= amp_step ? (amp_sum[16] ? `FSRT_AMP_FULL : amp_sum[15:0]) : amp_q;
      acc_q <= amp_step ? acc_in - amp_chunk : acc_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency reference and flags
  logic               reacc_q;
  logic signed [15:0] rstart_q;
  wire  signed [16:0] f_dn = 17'(freq_q) - 17'(step);
  wire  signed [16:0] f_up = 17'(freq_q) + 17'(step);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q     <= fsrt_pkg::ST_IDLE;
      freq_q   <= 16'sh0000;
      uvf_q    <= 1'b0;
      rsf_q    <= 1'b0;
      reacc_q  <= 1'b0;
      rstart_q <= 16'sh0000;
    end else begin
      st_q    <= st_d;
      uvf_q   <= uv_set | (uvf_q & ~uvf_clr);
      rsf_q   <= rsf_set | (rsf_q & ~rsf_clr);
      reacc_q <= reacc_set;
      if (reacc_set)
        rstart_q <= motor_speed_in;
      if (enter && st_d == fsrt_pkg::ST_SPOS)
        freq_q <= max_spd;
      else if (enter && st_d == fsrt_pkg::ST_SNEG)
        freq_q <= -max_spd;
      else if (st_q == fsrt_pkg::ST_SPOS)
        freq_q <= (tick && !match) ? (f_dn < 0 ? 16'sh0000 : f_dn[15:0]) : freq_q;
      else if (st_q == fsrt_pkg::ST_SNEG)
        freq_q <= (tick && !match) ? (f_up > 0 ? 16'sh0000 : f_up[15:0]) : freq_q;
      else if (st_q == fsrt_pkg::ST_HOLD)
        freq_q <= motor_speed_in;
      else if (st_q == fsrt_pkg::ST_IDLE || st_q == fsrt_pkg::ST_TRIP)
        freq_q <= 16'sh0000;
      else
        freq_q <= speed_reference_in;
    end
  end

  assign pulse_enable_out = ~(st_q == fsrt_pkg::ST_IDLE) & ~(st_q == fsrt_pkg::ST_BLOCK)
                          & ~(st_q == fsrt_pkg::ST_TRIP);
  assign freq_ref_out = freq_q;
  assign volt_ref_out = scalar ? amp_q : 16'h0000;
  assign current_ref_out = searching ? amp_q : 16'h0000;
  assign magnetize_out = st_q == fsrt_pkg::ST_MAGNET;
  assign vector_ctrl_out = ~scalar & ((st_q == fsrt_pkg::ST_RUN)
                         | (st_q == fsrt_pkg::ST_HOLD));
  assign link_reg_active_out = st_q == fsrt_pkg::ST_HOLD;
  assign link_reg_target_out = hold_lvl;
  assign reaccel_out = reacc_q;
  assign ramp_start_out = rstart_q;
  assign phase_loss_ignore_out = fs_sel | rt_sel;
  assign undervoltage_fault_out = uvf_q;
  assign ride_setting_fault_out = rsf_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: one wait-free cycle, unmapped reads zero
  wire [31:0] stat_word = {14'h0, rsf_q, uvf_q, 7'h0, st_q};
  wire [31:0] rd_mux = !bus_hit ? 32'h0 : (bus_idx == `FSRT_IDX_STAT) ? stat_word
                     : cfg_q[bus_idx];
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= bus_req;
      rdat_q <= bus_req ? rd_mux : 32'h0;
    end
  end
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_run_uv;
    st_q == fsrt_pkg::ST_RUN && scalar && rt_sel && en && below_uv;
  endsequence
  sequence s_blocked;
    !pulse_enable_out && !uvf_q;
  endsequence
  sequence s_hold_ret;
    st_q == fsrt_pkg::ST_HOLD && en && at_ret && !below_uv;
  endsequence

  scalar_uv_block_a: assert property (s_run_uv |=> s_blocked)
    else $error("scalar undervoltage did not block pulses quietly");
  rt_timeout_a: assert property (st_q == fsrt_pkg::ST_BLOCK && rt_timeout
    |=> uvf_q && st_q == fsrt_pkg::ST_TRIP)
    else $error("ride-through timeout raised no fault");
  ramp_entry_a: assert property ($rose(st_q == fsrt_pkg::ST_SRAMP)
    |-> amp_q == 16'h0000 ##1 freq_q == $past(speed_reference_in))
    else $error("scalar start not from zero voltage at reference");
  ramp_rise_a: assert property (st_q == fsrt_pkg::ST_SRAMP && $past(st_q) == st_q
    |-> amp_q >= $past(amp_q))
    else $error("voltage ramp went down");
  di_disable_a: assert property (st_q == fsrt_pkg::ST_IDLE && start && !uvf_q
    && scalar && di_dis |=> st_q == fsrt_pkg::ST_RUN)
    else $error("disabled flying start still ramped");
  search_start_a: assert property ($rose(st_q == fsrt_pkg::ST_SPOS)
    |-> freq_q == max_spd)
    else $error("search not begun at maximum speed");
  sweep_down_a: assert property (st_q == fsrt_pkg::ST_SPOS && $past(st_q) == st_q
    |-> freq_q <= $past(freq_q))
    else $error("positive sweep went up");
  vec_loss_a: assert property (st_q == fsrt_pkg::ST_RUN && !scalar && rt_sel && en
    && below_loss |=> link_reg_active_out && link_reg_target_out == hold_lvl)
    else $error("vector line loss not regulated");
  line_back_a: assert property (s_hold_ret |=> reaccel_out ##1 !reaccel_out)
    else $error("line return gave no single reacceleration pulse");
  phase_ign_a: assert property (phase_loss_ignore_out == (sel >= 3'h1 && sel <= 3'h3))
    else $error("phase loss ignore wrong for selection");
  bus_ack_a: assert property (bus_req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus answer not one cycle");
endmodule
`default_nettype wire

//--- tb/power_stage_model.sv
/*
 * power stage and link sensing model for the sequencer bench.
 * assumes the bench sets the supply goal and says whether the rotor
 * still has energy to feed back while the link is regulated.
 */
`timescale 1ns/1ns
`default_nettype none
module power_stage_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // bench controls
  input  wire logic [15:0] supply_goal_in,
  input  wire logic        kinetic_in,
  // from the sequencer
  input  wire logic        magnetize_in,
  input  wire logic        reg_active_in,
  input  wire logic [15:0] reg_target_in,
  // to the sequencer
  output logic [15:0]      link_out,
  output logic             mag_done_out
);
  logic [15:0] goal;
  logic [3:0]  mag_cnt_q;
  // regulation only holds the link while the rotor can still brake
  assign goal = (reg_active_in && kinetic_in && supply_goal_in < reg_target_in)
              ? reg_target_in : supply_goal_in;
  assign mag_done_out = &mag_cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // the link slews 4 V a cycle, never jumps
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      link_out <= 16'h012C;
      mag_cnt_q <= 4'h0;
    end else begin
      link_out <= (link_out > goal + 16'h0004) ? link_out - 16'h0004 :
                  (link_out + 16'h0004 < goal) ? link_out + 16'h0004 : goal;
      mag_cnt_q <= magnetize_in ? mag_cnt_q + {3'h0, ~&mag_cnt_q} : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_flying_start_ride_through_seq.sv
/*
 * bench of the flying start / ride-through sequencer.
 * assumes the power stage model and a shortened supervisory tick.
 */
`include "fsrt_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module test_flying_start_ride_through_seq;
  localparam int TK = 16;
  logic clk_in = 1'b0, sys_rst_in = 1'b1;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
  logic gen_enable_in = 1'b0, run_in = 1'b0, fs_disable_pin_in = 1'b0, kinetic = 1'b0;
  logic [15:0] link_voltage_in, volt_ref_out, current_ref_out, link_reg_target_out;
  logic [15:0] supply = 16'h012C;
  logic signed [15:0] speed_reference_in = 16'sh0000, motor_speed_in = 16'sh0000;
  logic signed [15:0] freq_ref_out, ramp_start_out, mx, mn;
  logic magnetize_done_in, pulse_enable_out, magnetize_out, vector_ctrl_out, seen;
  logic link_reg_active_out, reaccel_out, phase_loss_ignore_out;
  logic undervoltage_fault_out, ride_setting_fault_out;
  logic [7:0] fl;
  logic [31:0] rst_tab [8] = '{`FSRT_CTRL_RST, `FSRT_VRAMP_RST, `FSRT_SRCH_RST,
    `FSRT_TIME_RST, `FSRT_LVL1_RST, `FSRT_LVL2_RST, `FSRT_MAXS_RST, 32'h00000001};
  int error_cnt = 0, comparisons = 0, cycles = 0, n;
  assign fl = {volt_ref_out == 16'hFFFF, reaccel_out, vector_ctrl_out, link_reg_active_out,
               undervoltage_fault_out, ride_setting_fault_out, pulse_enable_out, magnetize_out};
  always #2 clk_in = ~clk_in;
  flying_start_ride_through_seq #(.TICK_CYCLES(TK)) dut (.clk_in, .sys_rst_in, .wb_cyc_in,
    .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .gen_enable_in, .run_in, .fs_disable_pin_in, .link_voltage_in, .speed_reference_in,
    .motor_speed_in, .magnetize_done_in, .pulse_enable_out, .freq_ref_out, .volt_ref_out,
    .current_ref_out, .magnetize_out, .vector_ctrl_out, .link_reg_active_out,
    .link_reg_target_out, .reaccel_out, .ramp_start_out, .phase_loss_ignore_out,
    .undervoltage_fault_out, .ride_setting_fault_out);
  power_stage_model stage (.clk_in, .sys_rst_in, .supply_goal_in(supply), .kinetic_in(kinetic),
    .magnetize_in(magnetize_out), .reg_active_in(link_reg_active_out),
    .reg_target_in(link_reg_target_out), .link_out(link_voltage_in),
    .mag_done_out(magnetize_done_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= s;
    do begin
      @(posedge clk_in);
      k++;
    end while (wb_ack_out !== 1'b1 && k < 50);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  // waits on one flag bit, noting magnetization and the frequency span
  task automatic till(input int b, input logic v, input int lim);
    n = 0;
    seen = 1'b0;
    mx = 16'sh8000;
    mn = 16'sh7FFF;
    while (fl[b] !== v && n < lim) begin
      @(posedge clk_in);
      n++;
      seen = seen | magnetize_out;
      if (freq_ref_out > mx) mx = freq_ref_out;
      if (freq_ref_out < mn) mn = freq_ref_out;
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, 4'hF);
      chk(q, rst_tab[i], "reset value");
    end
    wb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
    fs_disable_pin_in <= 1'b1;
    wb(1'b0, 8'h20, 32'h0, 4'hF);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, 8'h00, 32'h00001234, 4'h1);
    wb(1'b0, 8'h00, 32'h0, 4'hF);
    chk(q, 32'h00000034, "byte lane");
    $display("test registers done");
    speed_reference_in <= 16'sh01F4;
    wb(1'b1, 8'h04, 32'h00000004, 4'hF);
    wb(1'b1, 8'h00, 32'h00001801, 4'hF);
    gen_enable_in <= 1'b1;
    run_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({31'h0, fl[7]}, 32'h1, "input disables start");
    run_in <= 1'b0;
    fs_disable_pin_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    run_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({31'h0, pulse_enable_out}, 32'h1, "pulses at start");
    chk({16'h0, freq_ref_out}, 32'h000001F4, "start frequency");
    chk({31'h0, phase_loss_ignore_out}, 32'h1, "phase loss ignored");
    till(7, 1'b1, 5000);
    chk({31'h0, fl[7] && n >= 3 * TK}, 32'h1, "voltage ramp");
    wb(1'b1, 8'h00, 32'h00000002, 4'hF);
    supply <= 16'h0096;
    till(1, 1'b0, 200);
    chk({31'h0, undervoltage_fault_out}, 32'h0, "no fault on drop");
    supply <= 16'h012C;
    till(1, 1'b1, 200);
    chk({16'h0, freq_ref_out}, 32'h000001F4, "reference on return");
    chk({31'h0, fl[7]}, 32'h0, "voltage ramps again");
    till(7, 1'b1, 5000);
    supply <= 16'h0096;
    repeat (1990 * TK) @(posedge clk_in);
    chk({31'h0, undervoltage_fault_out}, 32'h0, "fault too early");
    till(3, 1'b1, 40 * TK);
    chk({31'h0, undervoltage_fault_out}, 32'h1, "fault after limit");
    gen_enable_in <= 1'b0;
    run_in <= 1'b0;
    supply <= 16'h012C;
    repeat (60) @(posedge clk_in);
    wb(1'b1, 8'h1C, 32'h00030000, 4'h4);
    wb(1'b0, 8'h1C, 32'h0, 4'hF);
    chk(q, {23'h0, fsrt_pkg::ST_IDLE}, "fault cleared");
    $display("test scalar done");
    wb(1'b1, 8'h00, 32'h00000031, 4'hF);
    motor_speed_in <= 16'sh0384;
    run_in <= 1'b1;
    @(posedge clk_in);
    gen_enable_in <= 1'b1;
    till(5, 1'b1, 8000);
    chk({16'h0, mx}, 32'h00000708, "search starts at max");
    chk({31'h0, seen}, 32'h0, "no magnetization");
    chk({31'h0, freq_ref_out >= 16'sh035C && freq_ref_out <= 16'sh03AC}, 32'h1, "match");
    chk({31'h0, n >= 118 * TK && n <= 130 * TK}, 32'h1, "sweep and filter");
    gen_enable_in <= 1'b0;
    motor_speed_in <= 16'sh0BB8;
    repeat (4) @(posedge clk_in);
    gen_enable_in <= 1'b1;
    till(5, 1'b1, 8000);
    chk({16'h0, mn}, 32'h0000F8F8, "reverse sweep");
    chk({31'h0, n >= 150 * TK}, 32'h1, "two sweeps");
    $display("test search done");
    wb(1'b1, 8'h00, 32'h00000032, 4'hF);
    kinetic <= 1'b1;
    supply <= 16'h00F0;
    till(4, 1'b1, 200);
    chk({16'h0, link_reg_target_out}, 32'h000000F5, "hold target");
    chk({31'h0, pulse_enable_out}, 32'h1, "regulated deceleration");
    supply <= 16'h0104;
    repeat (510 * TK) @(posedge clk_in);
    chk({31'h0, ride_setting_fault_out}, 32'h1, "setting fault");
    motor_speed_in <= 16'sh02BC;
    supply <= 16'h012C;
    till(6, 1'b1, 200);
    chk({16'h0, ramp_start_out}, 32'h000002BC, "reaccel from speed");
    kinetic <= 1'b0;
    supply <= 16'h0096;
    till(3, 1'b1, 200);
    chk({31'h0, undervoltage_fault_out}, 32'h1, "undervoltage");
    $display("test vector ride-through done");
    final_report();
  end
endmodule
`default_nettype wire
